// File: hdl/pbc_burst_seq.sv
// Burst word address sequencer: wrap, linear to row end, or continuous
`timescale 1ns/1ps
`default_nettype none
module pbc_burst_seq #(
    parameter int ADDR_W = 16,
    parameter int ROW_W  = 7
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Control
    input  wire logic              load,
    input  wire logic [ADDR_W-1:0] start_addr,
    input  wire logic              advance,
    input  wire logic              wrap_en,
    input  wire logic [2:0]        blen_code,
    // Sequence state
    output logic      [ADDR_W-1:0] word_addr_ff,
    output logic                   row_end_ff
);
    import pbc_pkg::*;

    logic [ADDR_W-1:0] wrap_mask;
    logic [ADDR_W-1:0] addr_inc;
    logic [ADDR_W-1:0] nxt_addr;
    logic              nxt_row_end;

    always_comb begin
        case (blen_code)
            BLEN_4:  wrap_mask = ADDR_W'(4'h3);
            BLEN_8:  wrap_mask = ADDR_W'(4'h7);
            BLEN_16: wrap_mask = ADDR_W'(8'h0f);
            BLEN_32: wrap_mask = ADDR_W'(8'h1f);
            default: wrap_mask = '0;
        endcase
    end

    assign addr_inc = word_addr_ff + ADDR_W'(1);

    always_comb begin
        nxt_addr    = word_addr_ff;
        nxt_row_end = row_end_ff;
        if (blen_code == BLEN_CONT) begin
            // [RL13] Continuous linear count
            nxt_addr = addr_inc;
        end else if (!wrap_en) begin
            // [RL11] Stop at row end
            if (&word_addr_ff[ROW_W-1:0]) begin
                nxt_row_end = 1'b1;
            end else begin
                nxt_addr = addr_inc;
            end
        end else begin
            // [RL10] Wrap inside burst length
            nxt_addr = (word_addr_ff & ~wrap_mask) | (addr_inc & wrap_mask);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            word_addr_ff <= '0;
            row_end_ff   <= 1'b0;
        end else if (load) begin
            word_addr_ff <= start_addr;
            row_end_ff   <= 1'b0;
        end else if (advance) begin
            word_addr_ff <= nxt_addr;
            row_end_ff   <= nxt_row_end;
        end
    end

endmodule : pbc_burst_seq
`default_nettype wire

// File: hdl/pbc_bus_config.sv
// Bus configuration register with decoded modes and burst wait timing
`timescale 1ns/1ps
`default_nettype none
module pbc_bus_config #(
    parameter int ADDR_W = 16,
    parameter int ROW_W  = 7
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Memory bus pins
    input  wire logic              burst_clk,
    input  wire logic              latch_n,
    input  wire logic              chip_en_n,
    input  wire logic              write_en_n,
    input  wire logic              out_en_n,
    input  wire logic              cfg_en,
    input  wire logic              reg_select_low,
    input  wire logic              reg_select_high,
    input  wire logic [15:0]       muxed_in,
    output logic      [15:0]       muxed_out_ff,
    output logic                   muxed_oe_ff,
    output logic                   wait_pin_ff,
    output logic                   wait_oe_ff,
    // Core side
    input  wire logic              refresh_busy,
    output logic      [15:0]       cfg_value_ff,
    output logic                   sync_mode_ff,
    output logic                   flash_mode_ff,
    output logic                   fixed_latency_ff,
    output logic      [3:0]        latency_cycles_ff,
    output logic      [1:0]        drive_strength_ff,
    output logic                   wrap_en_ff,
    output logic      [5:0]        burst_words_ff,
    output logic                   burst_valid_ff,
    output logic      [ADDR_W-1:0] burst_addr_ff,
    output logic                   burst_row_end_ff
);
    import pbc_pkg::*;

    // ========================================================================
    // Pin synchronisers
    logic [SYNC_W-1:0] pins_s1_ff;
    logic [SYNC_W-1:0] pins_s2_ff;
    logic              k_prev_ff;
    logic              l_prev_ff;

    always_ff @(posedge clock) begin
        if (rst) begin
            pins_s1_ff <= {8'h7e, 16'h0000};
            pins_s2_ff <= {8'h7e, 16'h0000};
            k_prev_ff  <= 1'b0;
            l_prev_ff  <= 1'b1;
        end else begin
            pins_s1_ff <= {burst_clk, latch_n, chip_en_n, write_en_n, out_en_n,
                           cfg_en, reg_select_low, reg_select_high, muxed_in};
            pins_s2_ff <= pins_s1_ff;
            k_prev_ff  <= pins_s2_ff[23];
            l_prev_ff  <= pins_s2_ff[22];
        end
    end

    logic        k_s;
    logic        l_n_s;
    logic        ce_n_s;
    logic        we_n_s;
    logic        oe_n_s;
    logic        cfg_s;
    logic        sel_lo_s;
    logic        sel_hi_s;
    logic [15:0] adq_s;
    logic        k_rise;
    logic        l_rise;
    logic        cfg_sel;

    assign {k_s, l_n_s, ce_n_s, we_n_s, oe_n_s, cfg_s, sel_lo_s, sel_hi_s, adq_s} = pins_s2_ff;
    assign k_rise  = k_s & ~k_prev_ff;
    assign l_rise  = l_n_s & ~l_prev_ff;
    // [RL17] Register select decode
    assign cfg_sel = cfg_s & ~ce_n_s & (sel_lo_s == SEL_LOW_CFG) & (sel_hi_s == SEL_HIGH_CFG);

    // ========================================================================
    // Configuration register
    function automatic logic has_reserved(input logic [15:0] v);
        logic [2:0] lat;
        logic [2:0] bl;
        lat = v[LATCNT_LSB +: 3];
        bl  = v[BLEN_LSB +: 3];
        has_reserved = (lat < LAT_3) || (lat > LAT_7)
                    || (v[DRIVE_LSB +: 2] == 2'h3)
                    || ((bl > BLEN_32) && (bl != BLEN_CONT)) || (bl == 3'h0)
                    // [RL18] Nonzero reserved bits fall back too
                    || ((v & CFG_RSVD_MSK) != 16'h0000);
    endfunction : has_reserved

    logic cfg_write;
    assign cfg_write = cfg_sel & l_rise & ~we_n_s;

    always_ff @(posedge clock) begin
        if (rst) begin
            // [RL16] Power-up defaults
            cfg_value_ff <= CFG_DEFAULT;
        end else if (cfg_write) begin
            // [RL15] Reserved contents replaced by defaults
            // [RL19] Bit n from line n
            cfg_value_ff <= has_reserved(adq_s) ? CFG_DEFAULT : adq_s;
        end
    end

    // [RL19] Read returns held value
    always_ff @(posedge clock) begin
        if (rst) begin
            muxed_out_ff <= 16'h0000;
            muxed_oe_ff  <= 1'b0;
        end else begin
            muxed_out_ff <= cfg_value_ff;
            muxed_oe_ff  <= cfg_sel & we_n_s & ~oe_n_s;
        end
    end

    // ========================================================================
    // Field decode
    // [RL14] Every mode output derives from one register
    always_ff @(posedge clock) begin
        if (rst) begin
            sync_mode_ff      <= ~CFG_DEFAULT[OPMODE_BIT];
            fixed_latency_ff  <= CFG_DEFAULT[LATTYPE_BIT];
            latency_cycles_ff <= 4'h4;
            drive_strength_ff <= CFG_DEFAULT[DRIVE_LSB +: 2];
            wrap_en_ff        <= ~CFG_DEFAULT[WRAP_BIT];
            burst_words_ff    <= 6'h00;
        end else begin
            // [RL1] Mode bit low selects synchronous
            sync_mode_ff     <= ~cfg_value_ff[OPMODE_BIT];
            // [RL3] Latency type select
            fixed_latency_ff <= cfg_value_ff[LATTYPE_BIT];
            // [RL5] Latency code decode
            case (cfg_value_ff[LATCNT_LSB +: 3])
                LAT_3:   latency_cycles_ff <= 4'h3;
                LAT_5:   latency_cycles_ff <= 4'h5;
                LAT_6:   latency_cycles_ff <= 4'h6;
                LAT_7:   latency_cycles_ff <= 4'h7;
                default: latency_cycles_ff <= 4'h4;
            endcase
            // [RL9] Drive strength decode
            drive_strength_ff <= cfg_value_ff[DRIVE_LSB +: 2];
            // [RL10] Wrap enable when bit is low
            wrap_en_ff <= ~cfg_value_ff[WRAP_BIT];
            // [RL12] Burst length decode, zero means continuous
            case (cfg_value_ff[BLEN_LSB +: 3])
                BLEN_4:  burst_words_ff <= 6'h04;
                BLEN_8:  burst_words_ff <= 6'h08;
                BLEN_16: burst_words_ff <= 6'h10;
                BLEN_32: burst_words_ff <= 6'h20;
                default: burst_words_ff <= 6'h00;
            endcase
        end
    end

    // ========================================================================
    // Flash-compatible mode detection
    logic addr_phase_edge_ff;

    always_ff @(posedge clock) begin
        if (rst) begin
            addr_phase_edge_ff <= 1'b0;
            flash_mode_ff      <= 1'b0;
        end else if (!l_n_s && !ce_n_s) begin
            if (k_rise) begin
                addr_phase_edge_ff <= 1'b1;
            end
        end else if (l_rise) begin
            // [RL2] Edge seen in address phase in synchronous mode means flash mode
            flash_mode_ff      <= sync_mode_ff & (addr_phase_edge_ff | k_rise);
            addr_phase_edge_ff <= 1'b0;
        end
    end

    // ========================================================================
    // Synchronous burst timing
    pbc_state_t state_ff;
    logic [3:0] lat_cnt_ff;
    logic       is_write_ff;
    logic       wait_act_ff;
    logic       start;
    logic       hold_ok;
    logic       now_ok;
    logic       early_ok;
    logic       seq_row_end;
    logic       seq_advance;
    logic       row_mode;
    logic       row_stop;
    logic       row_near;

    assign start    = sync_mode_ff & k_rise & ~l_n_s & ~ce_n_s & ~cfg_s;
    // Variable latency stretches reads only while refresh holds the array
    assign hold_ok  = fixed_latency_ff | is_write_ff | ~refresh_busy;
    // [RL4] Count edges from the start edge to the first word
    assign now_ok   = ((lat_cnt_ff + 4'h1) >= latency_cycles_ff) & hold_ok
                    & (~cfg_value_ff[WAITTIM_BIT] | ~wait_act_ff);
    assign early_ok = ((lat_cnt_ff + 4'h2) >= latency_cycles_ff) & hold_ok;
    assign seq_advance = (state_ff == PBC_DATA) & k_rise & ~seq_row_end;
    assign row_mode = ~wrap_en_ff & (cfg_value_ff[BLEN_LSB +: 3] != BLEN_CONT);
    assign row_stop = row_mode & (&burst_addr_ff[ROW_W-1:0]);
    assign row_near = row_mode & (burst_addr_ff[ROW_W-1:0] == ~ROW_W'(1));

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff    <= PBC_IDLE;
            lat_cnt_ff  <= LATCNT_RST;
            is_write_ff <= 1'b0;
        end else if (ce_n_s) begin
            state_ff   <= PBC_IDLE;
            lat_cnt_ff <= LATCNT_RST;
        end else begin
            case (state_ff)
                PBC_IDLE: begin
                    if (start) begin
                        state_ff    <= PBC_LATENCY;
                        lat_cnt_ff  <= LATCNT_RST;
                        is_write_ff <= ~we_n_s;
                    end
                end
                PBC_LATENCY: begin
                    if (k_rise) begin
                        lat_cnt_ff <= lat_cnt_ff + 4'h1;
                        if (now_ok) begin
                            state_ff <= PBC_DATA;
                        end
                    end
                end
                PBC_DATA: state_ff <= PBC_DATA;
                default: state_ff <= PBC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wait_act_ff    <= 1'b0;
            burst_valid_ff <= 1'b0;
        end else if (ce_n_s) begin
            wait_act_ff    <= 1'b0;
            burst_valid_ff <= 1'b0;
        end else if (state_ff == PBC_IDLE) begin
            wait_act_ff    <= start;
            burst_valid_ff <= 1'b0;
        end else if (k_rise) begin
            if (state_ff == PBC_LATENCY) begin
                burst_valid_ff <= now_ok;
                if (cfg_value_ff[WAITTIM_BIT]) begin
                    // [RL8] Wait released one cycle ahead of data
                    wait_act_ff <= ~early_ok;
                end else begin
                    // [RL7] Wait released together with data
                    wait_act_ff <= ~now_ok;
                end
            end else begin
                // [RL11] Row end halts data, wait asserted
                burst_valid_ff <= ~(seq_row_end | row_stop);
                wait_act_ff    <= seq_row_end | row_stop | (cfg_value_ff[WAITTIM_BIT] & row_near);
            end
        end
    end

    // [RL6] Wait pin level follows polarity bit
    always_ff @(posedge clock) begin
        if (rst) begin
            wait_pin_ff <= ~CFG_DEFAULT[WAITPOL_BIT];
            wait_oe_ff  <= 1'b0;
        end else begin
            wait_pin_ff <= cfg_value_ff[WAITPOL_BIT] ? wait_act_ff : ~wait_act_ff;
            wait_oe_ff  <= ~ce_n_s;
        end
    end

    pbc_burst_seq #(
        .ADDR_W (ADDR_W),
        .ROW_W  (ROW_W)
    ) u_seq (
        .clock        (clock),
        .rst          (rst),
        .load         (start & (state_ff == PBC_IDLE)),
        .start_addr   (adq_s[ADDR_W-1:0]),
        .advance      (seq_advance),
        .wrap_en      (wrap_en_ff),
        .blen_code    (cfg_value_ff[BLEN_LSB +: 3]),
        .word_addr_ff (burst_addr_ff),
        .row_end_ff   (seq_row_end)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            burst_row_end_ff <= 1'b0;
        end else begin
            burst_row_end_ff <= seq_row_end;
        end
    end

    // ========================================================================
    // Checks
    chk_reset_default: assert property (@(posedge clock) // [RL16]
        rst |=> (cfg_value_ff == CFG_DEFAULT))
        else $error("register not default after reset");

    chk_reserved_write: assert property (@(posedge clock) disable iff (rst) // [RL15]
        (cfg_write && has_reserved(adq_s)) |=> (cfg_value_ff == CFG_DEFAULT))
        else $error("reserved write not replaced by defaults");

    chk_write_take: assert property (@(posedge clock) disable iff (rst) // [RL19]
        (cfg_write && !has_reserved(adq_s)) |=> (cfg_value_ff == $past(adq_s)))
        else $error("valid write not stored");

    chk_sync_decode: assert property (@(posedge clock) disable iff (rst) // [RL1]
        $changed(cfg_value_ff) |=> ##1 (sync_mode_ff == ~$past(cfg_value_ff[OPMODE_BIT], 2)))
        else $error("operating mode decode wrong");

    chk_latency_decode: assert property (@(posedge clock) disable iff (rst) // [RL5]
        (cfg_value_ff[LATCNT_LSB +: 3] == LAT_3) ##1 (cfg_value_ff[LATCNT_LSB +: 3] == LAT_3)
        |-> (latency_cycles_ff == 4'h3))
        else $error("latency code decode wrong");

    chk_length_decode: assert property (@(posedge clock) disable iff (rst) // [RL12]
        (cfg_value_ff[BLEN_LSB +: 3] == BLEN_16) [*2] |-> (burst_words_ff == 6'h10))
        else $error("burst length decode wrong");

    chk_wait_polarity: assert property (@(posedge clock) disable iff (rst) // [RL6]
        $stable(cfg_value_ff) |=> (wait_pin_ff == ($past(cfg_value_ff[WAITPOL_BIT]) ?
                                   $past(wait_act_ff) : ~$past(wait_act_ff))))
        else $error("wait pin polarity wrong");

    chk_wait_early: assert property (@(posedge clock) disable iff (rst) // [RL8]
        ($rose(burst_valid_ff) && cfg_value_ff[WAITTIM_BIT] && $stable(cfg_value_ff)
         && (state_ff == PBC_DATA)) |-> !$past(wait_act_ff))
        else $error("wait not released one cycle before data");

    chk_wait_same: assert property (@(posedge clock) disable iff (rst) // [RL7]
        ($rose(burst_valid_ff) && !cfg_value_ff[WAITTIM_BIT] && $stable(cfg_value_ff))
        |-> $fell(wait_act_ff))
        else $error("wait not released with data");

    chk_latency_count: assert property (@(posedge clock) disable iff (rst) // [RL4]
        $rose(burst_valid_ff) |-> (lat_cnt_ff >= latency_cycles_ff))
        else $error("data phase entered before latency");

endmodule : pbc_bus_config
`default_nettype wire

// File: hdl/pbc_pkg.sv
// Constants, codes and types for the burst RAM bus configuration block
// Notes on behaviour
// [RL1] Mode bit: 0 synchronous, 1 asynchronous default
// [RL2] Clock edge while latch low: flash mode
// [RL3] Latency type: 0 variable, 1 fixed
// [RL4] Latency count: cycles to first data word
// [RL5] Latency codes 010..110 give three..seven cycles
// [RL6] Wait polarity: 0 low, 1 high default
// [RL7] Timing 0: data follows wait change
// [RL8] Timing 1: wait moves one cycle early
// [RL9] Drive codes: full, half default, quarter
// [RL10] Wrap bit: 0 wraps, 1 no wrap
// [RL11] No wrap: run to row end
// [RL12] Burst length codes 4..32 words, continuous
// [RL13] Continuous burst ignores all address boundaries
// [RL14] All bus modes come from this register
// [RL15] Reserved code written: defaults used instead
// [RL16] Defaults loaded at power-up reset
// [RL17] Select low 0, high 1 picks register
// [RL18] Controller writes zero to bits 9,7,6
// [RL19] Bit n from line n; reads return value
package pbc_pkg;

    // ========================================================================
    // Register layout
    localparam int          CFG_W        = 16;
    localparam logic [15:0] CFG_DEFAULT  = 16'h9d1f;
    localparam logic [15:0] CFG_RSVD_MSK = 16'h02c0;
    localparam int          OPMODE_BIT   = 15;
    localparam int          LATTYPE_BIT  = 14;
    localparam int          LATCNT_LSB   = 11;
    localparam int          WAITPOL_BIT  = 10;
    localparam int          WAITTIM_BIT  = 8;
    localparam int          DRIVE_LSB    = 4;
    localparam int          WRAP_BIT     = 3;
    localparam int          BLEN_LSB     = 0;

    // ========================================================================
    // Field codes
    localparam logic [2:0]  LAT_3        = 3'h2;
    localparam logic [2:0]  LAT_4        = 3'h3;
    localparam logic [2:0]  LAT_5        = 3'h4;
    localparam logic [2:0]  LAT_6        = 3'h5;
    localparam logic [2:0]  LAT_7        = 3'h6;
    localparam logic [1:0]  DRV_FULL     = 2'h0;
    localparam logic [1:0]  DRV_HALF     = 2'h1;
    localparam logic [1:0]  DRV_QUARTER  = 2'h2;
    localparam logic [2:0]  BLEN_4       = 3'h1;
    localparam logic [2:0]  BLEN_8       = 3'h2;
    localparam logic [2:0]  BLEN_16      = 3'h3;
    localparam logic [2:0]  BLEN_32      = 3'h4;
    localparam logic [2:0]  BLEN_CONT    = 3'h7;

    // ========================================================================
    // Register select and reset values
    localparam logic        SEL_LOW_CFG  = 1'b0;
    localparam logic        SEL_HIGH_CFG = 1'b1;
    localparam logic [3:0]  LATCNT_RST   = 4'h0;
    localparam int          SYNC_W       = 24;

    typedef enum logic [1:0] {PBC_IDLE, PBC_LATENCY, PBC_DATA} pbc_state_t;

endpackage : pbc_pkg

// File: sim/pbc_bus_config_bench.sv
// Self-checking bench for the bus configuration register block
`timescale 1ns/1ps
`default_nettype none
module pbc_bus_config_bench;
    import pbc_pkg::*;
    // ========================================
    // Signals and tables
    localparam int          ROW_W   = 7;
    localparam logic [15:0] DEF_CFG = 16'h9d1f;
    logic        clock, rst, burst_clk, latch_n, chip_en_n, write_en_n, out_en_n, cfg_en;
    logic        reg_select_low, reg_select_high, refresh_busy, muxed_oe_ff, wait_pin_ff;
    logic        wait_oe_ff, sync_mode_ff, flash_mode_ff, fixed_latency_ff, wrap_en_ff;
    logic        burst_valid_ff, burst_row_end_ff, rd_oe;
    logic [15:0] muxed_in, muxed_out_ff, cfg_value_ff, burst_addr_ff, rd_val;
    logic [3:0]  latency_cycles_ff;
    logic [1:0]  drive_strength_ff;
    logic [5:0]  burst_words_ff;
    int          miscompares = 0;
    int          cmp_count = 0;
    logic [2:0]  blens [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    logic [15:0] rsvd [10] = '{16'h051f, 16'h0d1f, 16'h3d1f, 16'h1d3f, 16'h1d18, 16'h1d1d,
                               16'h1d1e, 16'h051d, 16'h1d38, 16'h3d1e};
    logic [15:0] bcfg [8] = '{16'h5511, 16'h7012, 16'h5513, 16'h5514, 16'h551a, 16'h5517,
                              16'h1511, 16'h9d1f};
    logic [15:0] bst [8] = '{16'd2, 16'd5, 16'd14, 16'd30, 16'd125, 16'd126, 16'd0, 16'd0};
    initial clock = 1'b0;
    always #12.5 clock = ~clock;
    pbc_bus_config #(.ADDR_W(16), .ROW_W(ROW_W)) i_dut (
        .clock, .rst, .burst_clk, .latch_n, .chip_en_n, .write_en_n, .out_en_n, .cfg_en,
        .reg_select_low, .reg_select_high, .muxed_in, .muxed_out_ff, .muxed_oe_ff,
        .wait_pin_ff, .wait_oe_ff, .refresh_busy, .cfg_value_ff, .sync_mode_ff,
        .flash_mode_ff, .fixed_latency_ff, .latency_cycles_ff, .drive_strength_ff,
        .wrap_en_ff, .burst_words_ff, .burst_valid_ff, .burst_addr_ff, .burst_row_end_ff
    );
    pbc_ctrl_model i_ctrl (
        .clock, .muxed_out_ff, .muxed_oe_ff, .burst_clk, .latch_n, .chip_en_n,
        .write_en_n, .out_en_n, .cfg_en, .reg_select_low, .reg_select_high, .muxed_in
    );
    // ========================================
    // Checking tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic decode(input logic [15:0] v);
        check(cfg_value_ff, v, "held value");
        check(sync_mode_ff, !v[15], "mode");
        check(fixed_latency_ff, v[14], "latency type");
        check(latency_cycles_ff, {13'h0, v[13:11]} + 16'h1, "latency");
        check(drive_strength_ff, v[5:4], "drive");
        check(wrap_en_ff, !v[3], "wrap");
        check(burst_words_ff, (v[2:0] == 3'h7) ? 16'h0 : 16'h2 << v[2:0], "length");
    endtask : decode
    task automatic prog(input logic [15:0] v);
        i_ctrl.cfg_wr(1'b1, 1'b0, v);
        decode(v);
    endtask : prog
    // Beat k is sampled just before rise k+1, so settled values are seen
    task automatic burst(input logic [15:0] v, input logic [15:0] start, input logic busy);
        int          n, j;
        logic        act, row;
        logic [15:0] w, ea;
        prog(v);
        n = v[13:11] + 1;
        w = (v[2:0] == 3'h7) ? 16'h0 : 16'h2 << v[2:0];
        refresh_busy = busy;
        i_ctrl.addr_phase(start);
        for (int k = 0; k < n + 6; k++) begin
            i_ctrl.kclk();
            j = k - n;
            ea = start + 16'(j);
            if (!v[3] && w != 0) ea = (start & ~(w - 16'h1)) | (ea & (w - 16'h1));
            row = v[3] && w != 0 && (int'(start[ROW_W-1:0]) + j >= (1 << ROW_W));
            act = (k < n - v[8]);
            if (v[15]) begin
                check(burst_valid_ff, 1'b0, "async burst");
            end else if (busy) begin
                if (k == n) check(burst_valid_ff, 1'b0, "refresh stretch");
                if (k == n) @(negedge clock) refresh_busy = 1'b0;
            end else begin
                if (k <= n) check(wait_pin_ff, v[10] ? act : !act, "wait");
                check(burst_valid_ff, k >= n && !row, "valid");
                check(burst_row_end_ff, row, "row end");
                if (k >= n && !row) check(burst_addr_ff, ea, "address");
                check(wait_oe_ff, 1'b1, "wait driven");
            end
        end
        if (busy) check(burst_valid_ff, 1'b1, "stretch end");
        i_ctrl.release_bus();
        check(burst_valid_ff, 1'b0, "burst end");
        check(flash_mode_ff, !v[15], "flash detect");
    endtask : burst
    // ========================================
    // Test sequence
    initial begin
        rst = 1'b1;
        refresh_busy = 1'b0;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        decode(DEF_CFG);
        check(muxed_oe_ff, 1'b0, "idle lines");
        i_ctrl.cfg_rd(1'b1, 1'b0, rd_val, rd_oe);
        check(rd_val, DEF_CFG, "read default");
        check(rd_oe, 1'b1, "read drive");
        i_ctrl.cfg_rd(1'b0, 1'b0, rd_val, rd_oe);
        check(rd_oe, 1'b0, "other register");
        for (int c = 2; c <= 6; c++) prog((DEF_CFG & 16'hc7ff) | (16'(c) << 11));
        for (int d = 0; d <= 2; d++) prog((DEF_CFG & 16'hffcf) | (16'(d) << 4));
        foreach (blens[i]) prog((DEF_CFG & 16'hfff8) | {13'h0, blens[i]});
        foreach (rsvd[i]) begin
            prog(16'h1d1f);
            i_ctrl.cfg_wr(1'b1, 1'b0, rsvd[i]);
            check(cfg_value_ff, DEF_CFG, "reserved code");
        end
        prog(16'h1d1f);
        i_ctrl.cfg_wr(1'b0, 1'b0, 16'h5511);
        i_ctrl.cfg_wr(1'b1, 1'b1, 16'h5511);
        i_ctrl.cfg_rd(1'b1, 1'b0, rd_val, rd_oe);
        check(rd_val, 16'h1d1f, "unselected write");
        foreach (bcfg[i]) burst(bcfg[i], bst[i], i == 6);
        prog(16'h5511);
        i_ctrl.latch_only();
        check(flash_mode_ff, 1'b0, "full sync");
        test_done();
    end
    // The tests need well under 100 us; a hang is cut at 1 ms
    initial begin
        #1_000_000;
        miscompares++;
        test_done();
    end
endmodule : pbc_bus_config_bench
`default_nettype wire

// File: sim/pbc_ctrl_model.sv
// Memory controller model for configuration and burst accesses
`timescale 1ns/1ps
`default_nettype none
module pbc_ctrl_model (
    // Clock and device outputs
    input  wire logic        clock,
    input  wire logic [15:0] muxed_out_ff,
    input  wire logic        muxed_oe_ff,
    // Controller pins
    output var  logic        burst_clk,
    output var  logic        latch_n,
    output var  logic        chip_en_n,
    output var  logic        write_en_n,
    output var  logic        out_en_n,
    output var  logic        cfg_en,
    output var  logic        reg_select_low,
    output var  logic        reg_select_high,
    output logic      [15:0] muxed_in
);
    logic [15:0] drv_val;
    logic        drv_en;
    // ========================================
    // Shared lines
    // Released lines show inverted data so a stale value never passes
    assign muxed_in = muxed_oe_ff ? muxed_out_ff : (drv_en ? drv_val : ~drv_val);
    initial begin
        {burst_clk, cfg_en, drv_en, reg_select_low, reg_select_high} = 5'h0;
        {latch_n, chip_en_n, write_en_n, out_en_n} = 4'hf;
        drv_val = 16'h0;
    end
    // ========================================
    // Access tasks
    task automatic release_bus();
        @(negedge clock);
        {latch_n, chip_en_n, write_en_n, out_en_n, cfg_en, drv_en} = 6'h3c;
        repeat (4) @(negedge clock);
    endtask : release_bus
    task automatic select_cfg(input logic hi, input logic lo);
        @(negedge clock);
        {reg_select_high, reg_select_low, cfg_en, chip_en_n} = {hi, lo, 2'b10};
    endtask : select_cfg
    // Reserved bits always driven as zero
    task automatic cfg_wr(input logic hi, input logic lo, input logic [15:0] val);
        select_cfg(hi, lo);
        {write_en_n, latch_n, drv_en} = 3'h1;
        drv_val = val & 16'hfd3f;
        repeat (4) @(negedge clock);
        latch_n = 1'b1;
        repeat (4) @(negedge clock);
        release_bus();
    endtask : cfg_wr
    task automatic cfg_rd(input logic hi, input logic lo, output logic [15:0] val,
                          output logic oe);
        select_cfg(hi, lo);
        out_en_n = 1'b0;
        repeat (5) @(negedge clock);
        val = muxed_in;
        oe = muxed_oe_ff;
        release_bus();
    endtask : cfg_rd
    // Burst clock stands still low until the first beat
    task automatic addr_phase(input logic [15:0] start);
        @(negedge clock);
        {cfg_en, chip_en_n, latch_n, out_en_n, drv_en} = 5'h1;
        drv_val = start;
        repeat (4) @(negedge clock);
        #3;
    endtask : addr_phase
    // One 200 ns beat; the latch closes on the first falling edge
    task automatic kclk();
        burst_clk = 1'b1;
        #100;
        {burst_clk, latch_n, drv_en} = 3'h2;
        #100;
    endtask : kclk
    task automatic latch_only();
        addr_phase(16'h0);
        @(negedge clock);
        latch_n = 1'b1;
        release_bus();
    endtask : latch_only
endmodule : pbc_ctrl_model
`default_nettype wire
